//--- dma_bus_master_cycle_control.sv
`timescale 1ns/1ps
`include "dma_cycle_regs.svh"

module dma_bus_master_cycle_control import dma_cycle_pkg::*; (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  output logic [15:0] REG_RDATA,
  // Arbitration and transfer kind
  input wire logic BUS_GRANT,
  input wire logic XFER_READ,
  input wire logic XFER_WRITE,
  input wire logic XFER_WRITE_CHECK,
  // Slave answer
  input wire logic RECEIVED_SLAVE_SYNC,
  // FIFO and holding buffer flags
  input wire logic INPUT_BUFFER_FULL,
  input wire logic OUTPUT_BUFFER_LOADED,
  input wire logic FIFO_INPUT_READY,
  input wire logic FIFO_OUTPUT_READY,
  // Error and end conditions
  input wire logic BUS_PARITY_ERROR,
  input wire logic WRITE_CHECK_MISMATCH,
  input wire logic WORD_COUNT_OVERFLOW,
  input wire logic EXCEPTION_STOP,
  input wire logic TRANSFER_ERROR_IN,
  // Straps
  input wire logic SINGLE_CYCLE_STRAP,
  input wire logic BUS_HOLD_STRAP,
  input wire logic SECOND_BUS,
  // Bus side outputs
  output logic BUS_MASTER_FLAG,
  output logic BUS_BUSY_LINE,
  output logic ADDRESS_DRIVE_ENABLE,
  output logic MASTER_SYNC,
  output logic DATA_WORD_STROBE,
  output logic ADDRESS_ADVANCE,
  output logic REQUEST_RESTART,
  output logic SELECTION_ACK_RELEASE_ENABLE,
  // Status outputs
  output logic NONEXISTENT_MEMORY_ERROR,
  output logic TRANSFER_ERROR,
  output logic CYCLE_COUNT_FLAG,
  output logic NEXT_CYCLE_FLAG
);

  ctl_s q;
  ctl_s d;
  logic timeout_hit;
  logic bus_hold_mode;
  logic second_or_hold;
  logic cc_hold;
  logic cc_eff;
  logic sync_inhibit;
  logic read_gate;
  logic error_clear;
  logic bus_busy_release;
  logic enter_release;
  logic slave_seen;

  // ********************************************************************
  // Slave response timeout
  // ********************************************************************
  slave_timeout_timer slave_timeout_timer_inst (
    .clk(CLOCK),
    .rst(RST),
    .sync_active(q.msync),
    .slave_answer(RECEIVED_SLAVE_SYNC),
    .expired(timeout_hit)
  );

  // ********************************************************************
  // Mode and gating terms
  // ********************************************************************
  // Bus hold only on a dedicated second bus and never with the strap
  assign bus_hold_mode = BUS_HOLD_STRAP & q.hold_en & ~SINGLE_CYCLE_STRAP & SECOND_BUS;
  assign second_or_hold = (q.master & ~q.cc) | bus_hold_mode;
  // Direct hold on the cycle count, seen at once, not a cycle late
  assign cc_hold = q.nonexistent_memory_error | WORD_COUNT_OVERFLOW | EXCEPTION_STOP;
  assign cc_eff = q.cc | cc_hold;
  // Master sync inhibits, ORed together
  assign sync_inhibit = (second_or_hold & RECEIVED_SLAVE_SYNC)
    | (XFER_WRITE & INPUT_BUFFER_FULL)
    | (XFER_WRITE_CHECK & ~OUTPUT_BUFFER_LOADED);
  // Keeps the read deskew locked to the FIFO word rate
  assign read_gate = XFER_READ & second_or_hold & ~OUTPUT_BUFFER_LOADED;
  assign error_clear = REG_WRITE & (REG_ADDR == `CONTROL_OFS) & REG_WDATA[`CT_ERROR_CLEAR_BIT];
  assign slave_seen = q.msync & RECEIVED_SLAVE_SYNC;
  // End of sequence decision at cycle end
  always_comb begin
    if (BUS_PARITY_ERROR | WRITE_CHECK_MISMATCH) begin
      bus_busy_release = 1'b1;
    end else if (bus_hold_mode) begin
      bus_busy_release = q.transfer_error | WORD_COUNT_OVERFLOW | EXCEPTION_STOP;
    end else begin
      bus_busy_release = cc_eff | ~q.next;
    end
  end

  // ********************************************************************
  // Cycle sequencer and register port
  // ********************************************************************
  // One counter serves every sequencer interval since they never overlap; the slave timeout has its own
  always_comb begin
    d = q;
    enter_release = 1'b0;
    d.strobe = 1'b0;
    d.advance = 1'b0;
    d.restart = 1'b0;
    d.selection_acknowledge_en = 1'b1;
    // Register writes and reads
    if (REG_WRITE && (REG_ADDR == `CONTROL_OFS)) begin
      d.hold_en = REG_WDATA[`CT_BUS_HOLD_BIT];
    end
    d.rdata = 16'h0000;
    if (REG_READ) begin
      if (REG_ADDR == `STATUS_OFS) begin
        d.rdata[`ST_CYCLE_COUNT_BIT] = q.cc;
        d.rdata[`ST_NEXT_CYCLE_BIT] = q.next;
        d.rdata[`ST_BUS_BUSY_BIT] = q.busy;
        d.rdata[`ST_MASTER_SYNC_BIT] = q.msync;
        d.rdata[`ST_STATE_MSB:`ST_STATE_LSB] = q.st;
        d.rdata[`ST_NEM_BIT] = q.nonexistent_memory_error;
        d.rdata[`ST_TRE_BIT] = q.transfer_error;
      end else if (REG_ADDR == `CONTROL_OFS) begin
        d.rdata[`CT_BUS_HOLD_BIT] = q.hold_en;
      end
    end
    unique case (q.st)
      ST_IDLE: begin
        if (BUS_GRANT) begin
          d.master = 1'b1;
          d.busy = 1'b1;
          d.addr_en = 1'b1;
          d.cnt = 8'(`ADDR_DESKEW_CYC);
          d.st = ST_DESKEW;
        end
      end
      ST_DESKEW: begin
        if (read_gate) begin
          d.cnt = 8'(`ADDR_DESKEW_CYC);
        end else if (q.cnt == 8'h01) begin
          d.st = ST_ARMED;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      ST_ARMED: begin
        if (!sync_inhibit) begin
          d.msync = 1'b1;
          d.st = ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (RECEIVED_SLAVE_SYNC || timeout_hit) begin
          if (XFER_READ) begin
            enter_release = 1'b1;
          end else begin
            d.cnt = 8'(`DATA_DESKEW_CYC);
            d.st = ST_DATA_WAIT;
          end
        end
      end
      ST_DATA_WAIT: begin
        if (q.cnt == 8'h01) begin
          enter_release = 1'b1;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      ST_RELEASE: begin
        // Address and busy stay up while master sync is down
        if (q.cnt == 8'h01) begin
          d.cnt = 8'(`CYCLE_END_CYC);
          d.addr_en = 1'b0;
          d.advance = 1'b1;
          d.st = ST_CYCLE_END;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      ST_CYCLE_END: begin
        if (q.cnt != 8'h01) begin
          d.cnt = q.cnt - 8'h01;
        end else if (bus_busy_release) begin
          d.busy = 1'b0;
          d.master = 1'b0;
          d.st = ST_IDLE;
        end else begin
          d.restart = 1'b1;
          d.addr_en = 1'b1;
          d.cnt = 8'(`ADDR_DESKEW_CYC);
          d.st = ST_DESKEW;
        end
      end
      default: begin
        // Unused code: drop the bus rather than guess
        d.st = ST_IDLE;
        d.msync = 1'b0;
        d.busy = 1'b0;
        d.master = 1'b0;
        d.addr_en = 1'b0;
      end
    endcase
    // Start of sync release
    if (enter_release) begin
      d.st = ST_RELEASE;
      d.cnt = 8'(`SYNC_RELEASE_CYC);
      d.msync = 1'b0;
      d.strobe = 1'b1;
      if (bus_hold_mode || q.transfer_error || SINGLE_CYCLE_STRAP) begin
        d.cc = 1'b1;
      end else begin
        d.cc = ~q.cc;
      end
      if (bus_hold_mode) begin
        d.next = 1'b1;
      end else begin
        d.next = XFER_READ ? FIFO_OUTPUT_READY : FIFO_INPUT_READY;
      end
    end
    // Forced set off the bus or under a hard error
    if (!q.master || cc_hold) begin
      d.cc = 1'b1;
    end
    // Set wins over any clear in the same cycle
    if (timeout_hit) begin
      d.nonexistent_memory_error = 1'b1;
    end else if (slave_seen || error_clear) begin
      d.nonexistent_memory_error = 1'b0;
    end
    d.transfer_error = d.nonexistent_memory_error | TRANSFER_ERROR_IN;
  end

  // State register
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      q <= '0;
      q.cc <= 1'b1;
      q.selection_acknowledge_en <= 1'b1;
      q.hold_en <= `CT_BUS_HOLD_RST;
    end else begin
      q <= d;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign REG_RDATA = q.rdata;
  assign BUS_MASTER_FLAG = q.master;
  assign BUS_BUSY_LINE = q.busy;
  assign ADDRESS_DRIVE_ENABLE = q.addr_en;
  assign MASTER_SYNC = q.msync;
  assign DATA_WORD_STROBE = q.strobe;
  assign ADDRESS_ADVANCE = q.advance;
  assign REQUEST_RESTART = q.restart;
  assign SELECTION_ACK_RELEASE_ENABLE = q.selection_acknowledge_en;
  assign NONEXISTENT_MEMORY_ERROR = q.nonexistent_memory_error;
  assign TRANSFER_ERROR = q.transfer_error;
  assign CYCLE_COUNT_FLAG = q.cc;
  assign NEXT_CYCLE_FLAG = q.next;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);

  a_addr_deskew_wait: assert property ($rose(q.addr_en) |-> !q.msync[*8] ##1 !q.msync[*3])
    else $error("master sync raised inside address deskew");
  a_old_slave_sync: assert property ((q.st == ST_ARMED && second_or_hold && RECEIVED_SLAVE_SYNC)
    |=> !q.msync)
    else $error("master sync over previous slave sync");
  a_write_input_holding_buffer_full: assert property ((q.st == ST_ARMED && XFER_WRITE && INPUT_BUFFER_FULL)
    |=> !q.msync)
    else $error("master sync with input buffer full");
  a_wchk_output_holding_buffer_empty: assert property ((q.st == ST_ARMED && XFER_WRITE_CHECK
    && !OUTPUT_BUFFER_LOADED) |=> !q.msync)
    else $error("fetch started without output word");
  a_read_deskew_gate: assert property ((q.st == ST_DESKEW && read_gate)
    |=> q.cnt == 8'(`ADDR_DESKEW_CYC))
    else $error("read deskew ran without output word");
  a_timeout_sets_nem: assert property (timeout_hit |=> q.nonexistent_memory_error && q.transfer_error && q.rdata[9] == 1'b0)
    else $error("timeout did not set memory error");
  a_slave_clears_nem: assert property ((slave_seen && !timeout_hit) |=> !q.nonexistent_memory_error)
    else $error("slave sync left memory error set");
  a_data_deskew_len: assert property ((q.st == ST_SYNC && RECEIVED_SLAVE_SYNC && !XFER_READ)
    |=> (q.st == ST_DATA_WAIT)[*7] ##1 q.st == ST_RELEASE)
    else $error("data deskew length wrong");
  a_release_to_end: assert property ($rose(q.strobe) |-> (q.st == ST_RELEASE)[*4]
    ##1 (q.st == ST_CYCLE_END && q.advance))
    else $error("sync release length wrong");
  a_strobe_drops_sync: assert property (q.strobe |-> !q.msync && $past(q.msync))
    else $error("strobe without master sync drop");
  a_release_holds_bus: assert property (q.st == ST_RELEASE |-> q.addr_en && q.busy)
    else $error("address or busy dropped in sync release");
  a_read_skips_data: assert property ((q.st == ST_SYNC && RECEIVED_SLAVE_SYNC && XFER_READ)
    |=> q.st == ST_RELEASE)
    else $error("read did not skip data deskew");
  a_end_drops_addr: assert property (q.st == ST_CYCLE_END |-> !q.addr_en)
    else $error("address drive kept in cycle end");
  a_cc_forced_off: assert property (!q.master |=> q.cc)
    else $error("cycle count not forced off the bus");
  a_parity_releases: assert property ((q.st == ST_CYCLE_END && q.cnt == 8'h01
    && BUS_PARITY_ERROR) |=> !q.busy)
    else $error("parity error did not release busy");
  a_hold_next_set: assert property ((enter_release && bus_hold_mode) |=> q.next && q.cc)
    else $error("bus hold did not force next cycle");
  a_selection_acknowledge_enable: assert property (q.selection_acknowledge_en)
    else $error("acknowledge release enable dropped");

  c_read_cycle: cover property (q.st == ST_SYNC && RECEIVED_SLAVE_SYNC && XFER_READ);
  c_write_timeout: cover property (timeout_hit && XFER_WRITE);
  c_back_to_back: cover property (q.restart && !bus_hold_mode);
  c_hold_cycle: cover property (q.restart && bus_hold_mode);
  c_read_gate: cover property (q.st == ST_DESKEW && read_gate);

endmodule : dma_bus_master_cycle_control

//--- dma_cycle_regs.svh
`ifndef DMA_CYCLE_REGS_SVH
`define DMA_CYCLE_REGS_SVH

// ********************************************************************
// Clock and interval times
// ********************************************************************
`define CLK_PERIOD_NS 20
`define ADDR_DESKEW_NS 200
`define DATA_DESKEW_NS 125
`define SYNC_RELEASE_NS 75
`define CYCLE_END_NS 200
`define SLAVE_TIMEOUT_NS 10000

// Least times round up, the timeout rounds down
`define ADDR_DESKEW_CYC ((`ADDR_DESKEW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DATA_DESKEW_CYC ((`DATA_DESKEW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_RELEASE_CYC ((`SYNC_RELEASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYCLE_END_CYC ((`CYCLE_END_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLAVE_TIMEOUT_CYC (`SLAVE_TIMEOUT_NS / `CLK_PERIOD_NS)

// ********************************************************************
// Register offsets and fields
// ********************************************************************
`define STATUS_OFS 4'h0
`define CONTROL_OFS 4'h4
`define ST_CYCLE_COUNT_BIT 0
`define ST_NEXT_CYCLE_BIT 1
`define ST_BUS_BUSY_BIT 2
`define ST_MASTER_SYNC_BIT 3
`define ST_STATE_LSB 4
`define ST_STATE_MSB 6
`define ST_NEM_BIT 11
`define ST_TRE_BIT 14
`define CT_ERROR_CLEAR_BIT 0
`define CT_BUS_HOLD_BIT 1
`define CT_BUS_HOLD_RST 1'b0

`endif

//--- dma_cycle_pkg.sv
package dma_cycle_pkg;

  // ********************************************************************
  // Cycle sequencer states, Gray coded along the usual path
  // ********************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DESKEW = 3'h1,
    ST_ARMED = 3'h3,
    ST_SYNC = 3'h2,
    ST_DATA_WAIT = 3'h6,
    ST_RELEASE = 3'h7,
    ST_CYCLE_END = 3'h5
  } cycle_state_e;

  // Whole state of the cycle controller
  typedef struct packed {
    cycle_state_e st;
    logic [7:0] cnt;
    logic master;
    logic busy;
    logic addr_en;
    logic msync;
    logic strobe;
    logic advance;
    logic restart;
    logic nonexistent_memory_error;
    logic transfer_error;
    logic cc;
    logic next;
    logic selection_acknowledge_en;
    logic hold_en;
    logic [15:0] rdata;
  } ctl_s;

  // Whole state of the slave response timer
  typedef struct packed {
    logic [9:0] cnt;
    logic done;
    logic expired;
  } tmo_s;

endpackage : dma_cycle_pkg

//--- slave_timeout_timer.sv
`timescale 1ns/1ps
`include "dma_cycle_regs.svh"

module slave_timeout_timer import dma_cycle_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Master sync level and slave answer
  input wire logic sync_active,
  input wire logic slave_answer,
  // One-cycle pulse when the slave stayed silent too long
  output logic expired
);

  tmo_s q;
  tmo_s d;

  // ********************************************************************
  // Timer
  // ********************************************************************
  // Runs only while master sync is up; an answer cancels it until master sync drops
  always_comb begin
    d = q;
    d.expired = 1'b0;
    if (!sync_active) begin
      d.cnt = 10'h000;
      d.done = 1'b0;
    end else if (!q.done) begin
      if (slave_answer) begin
        d.done = 1'b1;
      end else if (q.cnt == 10'(`SLAVE_TIMEOUT_CYC - 1)) begin
        d.done = 1'b1;
        d.expired = 1'b1;
      end else begin
        d.cnt = q.cnt + 10'h001;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired = q.expired;

endmodule : slave_timeout_timer

//--- slave_memory_model.sv
`timescale 1ns/1ps

module slave_memory_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus handshake
  input wire logic master_sync,
  output logic slave_sync,
  // Answer wait, hold after release, stay silent
  input wire logic [7:0] answer_wait,
  input wire logic [7:0] hold_wait,
  input wire logic silent
);
  // ****************
  // Answer timing
  // ****************
  logic [7:0] cnt_q;

  // A slow hold keeps the answer up past release, as a lazy slave may
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slave_sync <= 1'b0;
      cnt_q <= 8'h00;
    end else if (master_sync && !slave_sync) begin
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q >= answer_wait && !silent) begin
        slave_sync <= 1'b1;
        cnt_q <= 8'h00;
      end
    end else if (!master_sync && slave_sync) begin
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q >= hold_wait) begin
        slave_sync <= 1'b0;
        cnt_q <= 8'h00;
      end
    end else begin
      cnt_q <= 8'h00;
    end
  end
endmodule : slave_memory_model

//--- dma_bus_master_cycle_control_tb.sv
`timescale 1ns/1ps

module dma_bus_master_cycle_control_tb;
  // ****************
  // Signals
  // ****************
  logic clk, rst, wr, rd, grant, x_rd, x_wr, x_wc, ssync, input_holding_buffer_full, output_holding_buffer_ld;
  logic fifo_in, fifo_out, par_err, wc_err, ovf, exc, tre_in, one_cyc, hold_strap, bus2;
  logic master, busy, addr_en, msync, strobe, advance, restart, selection_acknowledge_en, nonexistent_memory_error, transfer_error, cc, nxt;
  logic silent;
  logic [3:0] addr;
  logic [15:0] wdata, rdata;
  logic [7:0] hold_wait;
  int fail_count, checked;

  // Device and slave
  dma_bus_master_cycle_control dma_bus_master_cycle_control_inst (
    .CLOCK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WRITE(wr),
    .REG_READ(rd), .REG_RDATA(rdata), .BUS_GRANT(grant), .XFER_READ(x_rd),
    .XFER_WRITE(x_wr), .XFER_WRITE_CHECK(x_wc), .RECEIVED_SLAVE_SYNC(ssync),
    .INPUT_BUFFER_FULL(input_holding_buffer_full), .OUTPUT_BUFFER_LOADED(output_holding_buffer_ld),
    .FIFO_INPUT_READY(fifo_in), .FIFO_OUTPUT_READY(fifo_out), .BUS_PARITY_ERROR(par_err),
    .WRITE_CHECK_MISMATCH(wc_err), .WORD_COUNT_OVERFLOW(ovf), .EXCEPTION_STOP(exc),
    .TRANSFER_ERROR_IN(tre_in), .SINGLE_CYCLE_STRAP(one_cyc), .BUS_HOLD_STRAP(hold_strap),
    .SECOND_BUS(bus2), .BUS_MASTER_FLAG(master), .BUS_BUSY_LINE(busy),
    .ADDRESS_DRIVE_ENABLE(addr_en), .MASTER_SYNC(msync), .DATA_WORD_STROBE(strobe),
    .ADDRESS_ADVANCE(advance), .REQUEST_RESTART(restart),
    .SELECTION_ACK_RELEASE_ENABLE(selection_acknowledge_en), .NONEXISTENT_MEMORY_ERROR(nonexistent_memory_error),
    .TRANSFER_ERROR(transfer_error), .CYCLE_COUNT_FLAG(cc), .NEXT_CYCLE_FLAG(nxt));
  slave_memory_model slave_memory_model_inst (.clk(clk), .rst(rst), .master_sync(msync),
    .slave_sync(ssync), .answer_wait(8'h00), .hold_wait(hold_wait), .silent(silent));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************
  // Shared tasks
  // ****************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_read

  function automatic logic sig(input int s);
    case (s)
      0: return msync;
      1: return ssync;
      2: return busy;
      3: return advance;
      5: return nonexistent_memory_error;
      6: return transfer_error;
      default: return restart;
    endcase
  endfunction : sig

  // Counts edges until an output reaches a level; bounded so a hang cannot hide
  task automatic wait_lvl(input int s, input logic lvl, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (sig(s) !== lvl && n < 700);
  endtask : wait_lvl

  task automatic start;
    @(posedge clk);
    grant <= 1'b1;
    @(posedge clk);
    grant <= 1'b0;
  endtask : start

  task automatic kind(input int k);
    @(posedge clk);
    x_rd <= (k == 0);
    x_wr <= (k == 1);
    x_wc <= (k == 2);
  endtask : kind

  // One memory cycle; a negative dsk skips the deskew count
  task automatic mem_cycle(input int dsk, input int ans, input logic last);
    int n;
    wait_lvl(0, 1'b1, n);
    if (dsk >= 0) check("deskew", 16'(n), 16'(dsk));
    check("stale answer", 16'(ssync), 16'h0000);
    wait_lvl(1, 1'b1, n);
    wait_lvl(0, 1'b0, n);
    check("answer to drop", 16'(n), 16'(ans));
    check("strobe", 16'({strobe, addr_en, busy}), 16'h0007);
    wait_lvl(3, 1'b1, n);
    check("release", 16'(n), 16'h0004);
    check("addr drop", 16'({addr_en, busy}), 16'h0001);
    wait_lvl(last ? 2 : 4, !last, n);
    check("cycle end", 16'(n), 16'h000A);
  endtask : mem_cycle

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    @(posedge clk);
    #1;
    check("idle", 16'({master, busy, addr_en, msync, strobe, nonexistent_memory_error, transfer_error, nxt}), 16'h0000);
    check("ack count", 16'({selection_acknowledge_en, cc}), 16'h0003);
    start();
    repeat (14) @(posedge clk);
    #1;
    check("sync up", 16'(msync), 16'h0001);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk);
    #1;
    check("mid reset", 16'({busy, msync, master, cc, selection_acknowledge_en}), 16'h0003);
    @(posedge clk) rst <= 1'b0;
    $display("reset test done");
  endtask : t_reset

  task automatic t_regs;
    logic [15:0] d;
    reg_read(4'h0, d);
    check("status idle", d, 16'h0001);
    @(posedge clk);
    #1;
    check("read lapse", rdata, 16'h0000);
    reg_write(4'h8, 16'hFFFF);
    reg_read(4'h8, d);
    check("unmapped", d, 16'h0000);
    reg_read(4'h4, d);
    check("control reset", d, 16'h0000);
    $display("register test done");
  endtask : t_regs

  task automatic t_kinds;
    for (int k = 0; k < 3; k++) begin
      kind(k);
      start();
      mem_cycle(11, (k == 0) ? 1 : 8, 1'b1);
    end
    $display("kind test done");
  endtask : t_kinds

  // Second read cycle waits for the output word before its deskew runs
  task automatic t_read_gate;
    kind(0);
    fifo_out <= 1'b1;
    start();
    mem_cycle(11, 1, 1'b0);
    @(posedge clk);
    output_holding_buffer_ld <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    check("read gate", 16'(msync), 16'h0000);
    @(posedge clk);
    output_holding_buffer_ld <= 1'b1;
    mem_cycle(11, 1, 1'b1);
    @(posedge clk);
    fifo_out <= 1'b0;
    $display("read gate test done");
  endtask : t_read_gate

  task automatic t_inhibit;
    for (int k = 1; k < 3; k++) begin
      kind(k);
      input_holding_buffer_full <= (k == 1);
      output_holding_buffer_ld <= (k == 1);
      start();
      repeat (20) @(posedge clk);
      #1;
      check("inhibit", 16'(msync), 16'h0000);
      @(posedge clk);
      input_holding_buffer_full <= 1'b0;
      output_holding_buffer_ld <= 1'b1;
      mem_cycle(-1, 8, 1'b1);
    end
    kind(1);
    $display("inhibit test done");
  endtask : t_inhibit

  // Slave holds its answer long, so the second sync must wait for it
  task automatic t_b2b;
    int n;
    @(posedge clk);
    fifo_in <= 1'b1;
    hold_wait <= 8'h28;
    start();
    mem_cycle(11, 8, 1'b0);
    check("first count", 16'(cc), 16'h0000);
    mem_cycle(-1, 8, 1'b1);
    check("second count", 16'(cc), 16'h0001);
    wait_lvl(1, 1'b0, n);
    fifo_in <= 1'b0;
    hold_wait <= 8'h00;
    $display("back to back test done");
  endtask : t_b2b

  task automatic t_strap;
    @(posedge clk);
    one_cyc <= 1'b1;
    fifo_in <= 1'b1;
    start();
    mem_cycle(11, 8, 1'b1);
    @(posedge clk);
    one_cyc <= 1'b0;
    fifo_in <= 1'b0;
    $display("strap test done");
  endtask : t_strap

  task automatic t_hold;
    logic [15:0] d;
    @(posedge clk);
    hold_strap <= 1'b1;
    bus2 <= 1'b1;
    reg_write(4'h4, 16'h0002);
    reg_read(4'h4, d);
    check("hold bit", d, 16'h0002);
    start();
    mem_cycle(11, 8, 1'b0);
    check("hold flags", 16'({cc, nxt}), 16'h0003);
    @(posedge clk) par_err <= 1'b1;
    mem_cycle(-1, 8, 1'b1);
    @(posedge clk);
    par_err <= 1'b0;
    bus2 <= 1'b0;
    start();
    mem_cycle(11, 8, 1'b1);
    @(posedge clk) hold_strap <= 1'b0;
    reg_write(4'h4, 16'h0000);
    $display("hold test done");
  endtask : t_hold

  // Silent slave; first flag cleared by software, second by an answer
  task automatic t_timeout;
    int n;
    logic [15:0] d;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      silent <= 1'b1;
      fifo_in <= 1'b1;
      start();
      wait_lvl(0, 1'b1, n);
      repeat (490) @(posedge clk);
      #1;
      check("early flag", 16'(nonexistent_memory_error), 16'h0000);
      wait_lvl(5, 1'b1, n);
      check("flag time", 16'(n >= 8 && n <= 14), 16'h0001);
      wait_lvl(6, 1'b1, n);
      check("error delay", 16'(n), 16'h0001);
      reg_read(4'h0, d);
      check("status", d & 16'h4801, 16'h4801);
      wait_lvl(2, 1'b0, n);
      check("ends early", 16'(n < 40), 16'h0001);
      @(posedge clk);
      silent <= 1'b0;
      fifo_in <= 1'b0;
      if (i == 0) begin
        reg_write(4'h4, 16'h0001);
      end else begin
        start();
        mem_cycle(11, 8, 1'b1);
      end
      repeat (2) @(posedge clk);
      #1;
      check("flag cleared", 16'({nonexistent_memory_error, transfer_error}), 16'h0000);
    end
    $display("timeout test done");
  endtask : t_timeout

  // ****************
  // Main sequence and watchdog
  // ****************
  initial begin
    {rd, wr, grant, x_rd, x_wc, ssync, fifo_in, fifo_out, par_err, wc_err} = '0;
    {ovf, exc, tre_in, one_cyc, hold_strap, bus2, input_holding_buffer_full, silent} = '0;
    {x_wr, output_holding_buffer_ld, rst} = 3'h7;
    addr = 4'h0;
    wdata = 16'h0000;
    hold_wait = 8'h00;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_kinds();
    t_read_gate();
    t_inhibit();
    t_b2b();
    t_strap();
    t_hold();
    t_timeout();
    print_verdict();
  end

  // Tests take under 2000 cycles; twenty times that is a hang
  initial begin
    #800000;
    fail_count++;
    print_verdict();
  end
endmodule : dma_bus_master_cycle_control_tb
